// ===== gitm_chk.sv
`timescale 1ns/1ns
module gitm_chk (
  input wire       clk,          // Clock
  input wire       nrst,         // Reset, active low
  input wire [7:0] addr,         // Byte address
  input wire [7:0] wdata,        // Write data
  input wire       wr,           // Write strobe
  input wire       rd,           // Read strobe
  input wire [7:0] rdata,        // Read data
  input wire [7:0] ch_rx_ready,  // Rx ready
  input wire [7:0] ch_line_err,  // Line error
  input wire [7:0] ch_rx_tmo,    // Rx timeout
  input wire [7:0] ch_tx_ready,  // Tx ready
  input wire [7:0] ch_modem,     // Modem event
  input wire       all_asleep,   // All asleep
  input wire       pin_lvl_read, // Pin level read
  input wire       timer_out,    // Timer output
  input wire       pin0_route,   // Route to pin 0
  input wire       irq           // Interrupt
);
  logic [7:0] fl;
  logic [2:0] c0, c1, c6, c7;
  function automatic [2:0] code(input integer c);
    if (ch_rx_ready[c] | ch_line_err[c]) code = 3'h1;
    else if (ch_rx_tmo[c]) code = 3'h2;
    else if (ch_tx_ready[c]) code = 3'h3;
    else if (ch_modem[c]) code = 3'h4;
    else code = 3'h0;
  endfunction
  always_comb begin
    fl = ch_rx_ready | ch_line_err | ch_rx_tmo | ch_tx_ready | ch_modem;
    c0 = code(0);
    c1 = code(1);
    c6 = code(6);
    c7 = code(7);
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_rd(a); rd && addr == a; endsequence
  sequence s_cmd(k); wr && addr == 8'h84 && wdata[3:0] == k; endsequence
  a_rdata_holds: assert property (!rd |=> $stable(rdata))
    else $error("read data moved");
  a_flag_bits: assert property (s_rd(8'h80) |=>
    rdata[7:1] == $past(fl[7:1])) else $error("flag byte wrong");
  a_code_top: assert property (s_rd(8'h83) |=>
    rdata[7:2] == {$past(c7), $past(c6)}) else $error("top codes wrong");
  a_code_ch1: assert property (s_rd(8'h81) |=>
    rdata[5:3] == $past(c1)) else $error("channel 1 code wrong");
  a_ch0_uart_first: assert property (s_rd(8'h81) && c0 != 3'h0
    |=> rdata[2:0] == $past(c0)) else $error("channel 0 order wrong");
  a_status_bits: assert property (s_rd(8'h84) |=>
    rdata[7:1] == 7'h00) else $error("status upper bits set");
  a_pin_pulse: assert property (pin_lvl_read ==
    (rd && addr == 8'h90)) else $error("pin read pulse wrong");
  a_reset_cmd: assert property (s_cmd(4'hB) |=>
    timer_out && !pin0_route) else $error("timer defaults lost");
  a_stop_high: assert property (s_cmd(4'hA) |=> timer_out)
    else $error("stop left output low");
  a_wake_irq: assert property ($fell(all_asleep) |=> irq)
    else $error("wake gave no interrupt");
endmodule
bind gitm_global_irq_timer gitm_chk chk_u (.clk, .nrst, .addr, .wdata,
  .wr, .rd, .rdata, .ch_rx_ready, .ch_line_err, .ch_rx_tmo, .ch_tx_ready,
  .ch_modem, .all_asleep, .pin_lvl_read, .timer_out, .pin0_route, .irq);

// ===== gitm_global_irq_timer.v
`timescale 1ns/1ns
`include "gitm_map.vh"
// Notes on behaviour
// [RULE_01] Status word reads zero after reset
// [RULE_02] Wake after all-sleep raises wake-up interrupt
// [RULE_03] Flag byte: one bit per channel
// [RULE_04] Flag drops when channel source clears
// [RULE_05] Three-bit code per channel, bits 31:8
// [RULE_06] Global sources only in channel 0 code
// [RULE_07] Code reports highest pending source
// [RULE_08] Channel 0 UART sources beat global sources
// [RULE_09] Receive buffer read clears rx and timeout
// [RULE_10] Line status read clears line error
// [RULE_11] Status register read clears tx, flow
// [RULE_12] Modem status read clears modem interrupt
// [RULE_13] Timer command read clears timer interrupt
// [RULE_14] Pin level read clears pin interrupt
// [RULE_15] Timer clock internal or external pin
// [RULE_16] One-shot and re-triggerable modes
// [RULE_17] Enabled timer timeout raises channel 0 interrupt
// [RULE_18] Period is high:low bytes
// [RULE_19] Period reads return programmed value
// [RULE_20] Period resets zero; reset command keeps it
// [RULE_21] Timer output routable to pin 0
// [RULE_22] Command nibble self-clears; read shows 0x01
// [RULE_23] Reset restores timer defaults
// [RULE_24] Command code table
// [RULE_25] Host programs timer only while stopped
// [RULE_26] Clear-on-read only on completed register read
module gitm_global_irq_timer (
  input  wire       clk,          // System clock
  input  wire       nrst,         // Async reset, active low
  input  wire [7:0] addr,         // Register byte address
  input  wire [7:0] wdata,        // Write data
  input  wire       wr,           // Write strobe
  input  wire       rd,           // Read strobe
  output reg  [7:0] rdata,        // Read data, cycle after rd
  input  wire [7:0] ch_rx_ready,  // Receive data ready per channel
  input  wire [7:0] ch_line_err,  // Line error pending per channel
  input  wire [7:0] ch_rx_tmo,    // Receive timeout per channel
  input  wire [7:0] ch_tx_ready,  // Transmit ready per channel
  input  wire [7:0] ch_modem,     // Modem/flow/special event per chan
  input  wire       all_asleep,   // All eight channels asleep
  input  wire       pin_irq,      // Multipurpose pin interrupt
  input  wire [7:0] pin_level,    // Multipurpose pin levels
  output wire       pin_lvl_read, // Pin level register read pulse
  input  wire       clk_125_tick, // Internal clock tick, master
  input  wire       clk_62_tick,  // Internal clock tick, slave
  input  wire       external_timer_clock_in, // External timer clock
  output reg        timer_out,    // Timer output level
  output wire       pin0_route,   // Timer drives multipurpose pin 0
  output wire       irq           // Any pending interrupt
);
  reg  [7:0]  period_low;
  reg  [7:0]  period_high;
  reg  [7:0]  ctrl;
  reg         ien;
  reg         oneshot;
  reg         extclk;
  reg         routed;
  reg         running;
  reg         timed_out;
  reg         tmr_pend;
  reg         wake_pend;
  reg         asleep_d;
  reg         ext_d;
  reg  [15:0] count;
  wire [15:0] period;
  wire [7:0]  chan_flags;
  wire [23:0] codes;
  reg  [2:0]  code0;
  wire        tick;
  wire        cmd_wr;
  wire [3:0]  cmd;
  wire        rd_flags;
  wire        rd_tcmd;
  wire        reset_cmd;
  wire        tmo;
  wire [15:0] half;
  wire [15:0] next_count;
  reg         next_ien;
  reg         next_oneshot;
  reg         next_extclk;
  reg         next_routed;
  reg         next_running;
  reg         next_timed_out;
  reg  [15:0] next_cnt;
  reg         next_timer_out;
  reg  [7:0]  next_rdata;
  wire [7:0]  stat_byte;
  wire [31:0] status_word;
  wire        stopped;

  assign period = {period_high, period_low}; // see [RULE_18]
  assign half   = {1'b0, period[15:1]};

  // Only completed reads of the exact byte carry side effects
  assign rd_flags     = rd && (addr == `GITM_A_FLAGS);  // see [RULE_26]
  assign rd_tcmd      = rd && (addr == `GITM_A_TCMD);   // see [RULE_26]
  assign pin_lvl_read = rd && (addr == `GITM_A_PINLVL); // see [RULE_14]
  assign cmd_wr    = wr && (addr == `GITM_A_TCMD);
  assign cmd       = wdata[3:0];                         // see [RULE_22]
  assign reset_cmd = cmd_wr && (cmd == `GITM_K_RESET);
  assign stopped   = !running;

  // Status reads 0x01 only while enabled and pending
  assign stat_byte = (tmr_pend && ien) ? `GITM_STAT_PEND :
                     `GITM_ZERO8;                        // see [RULE_22]

  // Clock source select; external clock sampled for rising edges
  assign tick = extclk ? (external_timer_clock_in & ~ext_d) :
                ctrl[`GITM_CTRL_SLAVE] ? clk_62_tick :
                clk_125_tick;                            // see [RULE_15]

  // Timeout when the count plus one reaches the period
  assign tmo = running && tick && !timed_out &&
               (count + `GITM_ONE16 >= period);
  assign next_count = tmo ? `GITM_ZERO16 : count + `GITM_ONE16;

  genvar g;
  generate
    for (g = 0; g < `GITM_NCHAN; g = g + 1) begin : chan
      wire any = ch_rx_ready[g] | ch_line_err[g] | ch_rx_tmo[g] |
                 ch_tx_ready[g] | ch_modem[g];
      reg  [2:0] c;
      always @* begin
        if (ch_rx_ready[g] | ch_line_err[g])
          c = `GITM_C_RXLINE;                            // see [RULE_07]
        else if (ch_rx_tmo[g])
          c = `GITM_C_RXTO;
        else if (ch_tx_ready[g])
          c = `GITM_C_TX;
        else if (ch_modem[g])
          c = `GITM_C_MODEM;
        else
          c = `GITM_C_NONE;
      end
      // Sources clear in the channels themselves; flags follow
      assign chan_flags[g] = any;                  // see [RULE_03] [RULE_04]
      if (g == 0) begin : c0
        always @* begin
          if (any)
            code0 = c;                                   // see [RULE_08]
          else if (tmr_pend && ien)
            code0 = `GITM_C_TIMER;                       // see [RULE_06]
          else if (pin_irq)
            code0 = `GITM_C_PIN;
          else
            code0 = `GITM_C_NONE;
        end
        assign codes[2:0] = code0;                       // see [RULE_05]
      end else begin : cn
        assign codes[3*g+2:3*g] = c;                     // see [RULE_06]
      end
    end
  endgenerate

  // Interrupt clears by reading in the channels, see [RULE_09]
  // [RULE_10] [RULE_11] [RULE_12]: flags drop when inputs drop.
  assign irq = (|chan_flags) | wake_pend | (tmr_pend & ien) | pin_irq;
  assign pin0_route = routed;                            // see [RULE_21]
  assign status_word = {codes, chan_flags};              // see [RULE_05]

  // Wake-up detect; the set wins over the clearing read
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      asleep_d  <= 1'b0;
      wake_pend <= 1'b0;                                 // see [RULE_01]
    end else begin
      asleep_d <= all_asleep;
      if (asleep_d && !all_asleep)
        wake_pend <= 1'b1;                               // see [RULE_02]
      else if (rd_flags)
        wake_pend <= 1'b0;
    end
  end

  // External clock sample for rising edge detect
  always @(posedge clk or negedge nrst) begin
    if (!nrst)
      ext_d <= 1'b0;
    else
      ext_d <= external_timer_clock_in;
  end

  // Own control register: internal clock configuration select
  always @(posedge clk or negedge nrst) begin
    if (!nrst)
      ctrl <= `GITM_ZERO8;
    else if (wr && addr == `GITM_A_CTRL)
      ctrl <= wdata;
  end

  // Period writes blocked while running
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      period_low  <= `GITM_ZERO8;                        // see [RULE_20]
      period_high <= `GITM_ZERO8;
    end else begin
      if (wr && stopped && addr == `GITM_A_TLOW)
        period_low <= wdata;                             // see [RULE_25]
      if (wr && stopped && addr == `GITM_A_THIGH)
        period_high <= wdata;
    end
  end

  // Mode commands only take effect while the timer is stopped; the reset command clears the modes at any time
  always @* begin
    next_ien     = ien;
    next_oneshot = oneshot;
    next_extclk  = extclk;
    next_routed  = routed;
    if (cmd_wr) begin
      case (cmd)                                         // see [RULE_24]
        `GITM_K_IEN:     if (stopped) next_ien = 1'b1;
        `GITM_K_IDIS:    if (stopped) next_ien = 1'b0;
        `GITM_K_ONESHOT: if (stopped) next_oneshot = 1'b1;
        `GITM_K_RETRIG:  if (stopped) next_oneshot = 1'b0;
        `GITM_K_INTCLK:  if (stopped) next_extclk = 1'b0;
        `GITM_K_EXTCLK:  if (stopped) next_extclk = 1'b1;
        `GITM_K_ROUTE:   if (stopped) next_routed = 1'b1;
        `GITM_K_UNROUTE: if (stopped) next_routed = 1'b0;
        `GITM_K_RESET: begin
          next_ien     = 1'b0;                           // see [RULE_23]
          next_oneshot = 1'b0;
          next_extclk  = 1'b0;
          next_routed  = 1'b0;
        end
        default: ;
      endcase
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ien     <= 1'b0;                                   // see [RULE_23]
      oneshot <= 1'b0;
      extclk  <= 1'b0;
      routed  <= 1'b0;
    end else begin
      ien     <= next_ien;
      oneshot <= next_oneshot;
      extclk  <= next_extclk;
      routed  <= next_routed;
    end
  end

  // Counter and output next state
  always @* begin
    next_running   = running;
    next_timed_out = timed_out;
    next_cnt       = count;
    next_timer_out = timer_out;
    if (running && tick && !timed_out) begin
      next_cnt = next_count;                             // see [RULE_16]
      if (tmo && oneshot) begin
        next_timed_out = 1'b1;
        next_timer_out = 1'b0;
      end else if (tmo) begin
        next_timer_out = 1'b1;
      end else if (!oneshot && (count + `GITM_ONE16 >= half)) begin
        next_timer_out = 1'b0;
      end
    end
    if (cmd_wr) begin
      case (cmd)
        `GITM_K_START: begin
          // Period of zero keeps the timer disabled
          if (period != `GITM_ZERO16 &&
              (stopped || (oneshot && !timed_out))) begin
            next_running   = 1'b1;
            next_cnt       = `GITM_ZERO16;
            next_timer_out = 1'b1;
          end
        end
        `GITM_K_STOP: begin
          next_running   = 1'b0;
          next_timed_out = 1'b0;
          next_timer_out = 1'b1;
        end
        `GITM_K_RESET: begin
          next_running   = 1'b0;                         // see [RULE_23]
          next_timed_out = 1'b0;
          next_timer_out = 1'b1;
          next_cnt       = `GITM_ZERO16;
        end
        default: ;
      endcase
    end
  end

  // Output idles high whenever the timer is stopped
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      running   <= 1'b0;
      timed_out <= 1'b0;
      count     <= `GITM_ZERO16;
      timer_out <= 1'b1;
    end else begin
      running   <= next_running;
      timed_out <= next_timed_out;
      count     <= next_cnt;
      timer_out <= next_timer_out;
    end
  end

  // Reset command clears; otherwise a timeout wins over the read
  always @(posedge clk or negedge nrst) begin
    if (!nrst)
      tmr_pend <= 1'b0;
    else if (reset_cmd)
      tmr_pend <= 1'b0;                                  // see [RULE_23]
    else if (tmo && ien)
      tmr_pend <= 1'b1;                                  // see [RULE_17]
    else if (rd_tcmd)
      tmr_pend <= 1'b0;                                  // see [RULE_13]
  end

  // Read data mux; the registered byte stands until the next read
  always @* begin
    next_rdata = rdata;
    if (rd) begin
      case (addr)
        `GITM_A_FLAGS:    next_rdata = status_word[7:0];
        `GITM_A_CODE_LO:  next_rdata = status_word[15:8];
        `GITM_A_CODE_MID: next_rdata = status_word[23:16];
        `GITM_A_CODE_HI:  next_rdata = status_word[31:24];
        `GITM_A_TCMD:     next_rdata = stat_byte;
        `GITM_A_TLOW:     next_rdata = period_low;       // see [RULE_19]
        `GITM_A_THIGH:    next_rdata = period_high;
        `GITM_A_CTRL:     next_rdata = ctrl;
        default:          next_rdata = `GITM_ZERO8;
      endcase
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst)
      rdata <= `GITM_ZERO8;
    else
      rdata <= next_rdata;
  end
endmodule

// ===== gitm_global_irq_timer_tb.sv
`timescale 1ns/1ns
module gitm_global_irq_timer_tb;
  reg        clk = 0, nrst = 0, wr = 0, rd = 0, asleep = 0, raise = 0;
  reg  [7:0] addr = 8'h00, wdata = 8'h00, d;
  reg  [7:0] rx = 8'h00, le = 8'h00, to = 8'h00, tx = 8'h00, md = 8'h00;
  wire [7:0] rdata;
  wire       pin_irq, pin_rd, tout, route, irq;
  integer    n_mismatch = 0, n_checks = 0, cyc = 0;
  always #5 clk = ~clk;
  gitm_global_irq_timer dut_u (.clk, .nrst, .addr, .wdata, .wr, .rd,
    .rdata, .ch_rx_ready(rx), .ch_line_err(le), .ch_rx_tmo(to),
    .ch_tx_ready(tx), .ch_modem(md), .all_asleep(asleep), .pin_irq,
    .pin_level(8'h00), .pin_lvl_read(pin_rd), .clk_125_tick(nrst),
    .clk_62_tick(1'b0), .external_timer_clock_in(1'b0),
    .timer_out(tout), .pin0_route(route), .irq);
  gitm_pin_model pin_u (.clk, .nrst, .raise, .pin_lvl_read(pin_rd),
    .pin_irq);
  task chk(input string nm, input [7:0] s, e);
    n_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task bw(input [7:0] a, v);
    @(posedge clk);
    {addr, wdata, wr} <= {a, v, 1'b1};
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task br(input [7:0] a);
    @(posedge clk);
    {addr, rd} <= {a, 1'b1};
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task t_reset;
    for (int a = 8'h80; a < 8'h88; a++) begin
      br(a[7:0]);
      chk("reset byte", d, 8'h00);
    end
    $display("test reset done");
  endtask
  task t_codes;
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      {rx, le, to, tx, md} <= 40'h82 << (8 * (4 - i));
      br(8'h83);
      chk("ch7 code", {5'h0, d[7:5]}, i < 2 ? 8'h01 : i[7:0]);
      br(8'h81);
      chk("ch1 code", {5'h0, d[5:3]}, i < 2 ? 8'h01 : i[7:0]);
      br(8'h80);
      chk("flags", d, 8'h82);
    end
    @(posedge clk);
    {rx, le, to, tx, md} <= 40'h0;
    br(8'h80);
    chk("flags clear", d, 8'h00);
    $display("test codes done");
  endtask
  task t_ch0;
    @(posedge clk);
    {raise, tx} <= {1'b1, 8'h01};
    br(8'h81);
    chk("ch0 uart first", {5'h0, d[2:0]}, 8'h03);
    @(posedge clk);
    tx <= 8'h00;
    raise <= 1'b0;
    br(8'h81);
    chk("ch0 pin", {5'h0, d[2:0]}, 8'h06);
    br(8'h90);
    br(8'h81);
    chk("pin cleared", {5'h0, d[2:0]}, 8'h00);
    $display("test channel 0 done");
  endtask
  task t_timer;
    bw(8'h86, 8'h04);
    bw(8'h87, 8'h00);
    br(8'h86);
    chk("period low", d, 8'h04);
    br(8'h87);
    chk("period high", d, 8'h00);
    bw(8'h84, 8'h01);
    bw(8'h84, 8'h03);
    bw(8'h84, 8'h09);
    repeat (12) @(posedge clk);
    chk("one-shot out", {7'h0, tout}, 8'h00);
    br(8'h81);
    chk("timer code", {5'h0, d[2:0]}, 8'h07);
    br(8'h84);
    chk("status pending", d, 8'h01);
    br(8'h84);
    chk("status cleared", d, 8'h00);
    bw(8'h86, 8'h09);
    br(8'h86);
    chk("blocked write", d, 8'h04);
    bw(8'h84, 8'h0A);
    chk("stopped out", {7'h0, tout}, 8'h01);
    bw(8'h84, 8'h07);
    chk("routed", {7'h0, route}, 8'h01);
    bw(8'h84, 8'h0B);
    chk("unrouted", {7'h0, route}, 8'h00);
    br(8'h86);
    chk("period kept", d, 8'h04);
    $display("test timer done");
  endtask
  task t_retrig;
    bw(8'h84, 8'h09);
    repeat (2) @(posedge clk);
    #1 chk("retrig low", {7'h0, tout}, 8'h00);
    repeat (2) @(posedge clk);
    #1 chk("retrig high", {7'h0, tout}, 8'h01);
    bw(8'h84, 8'h0A);
    $display("test retrig done");
  endtask
  task t_wake;
    @(posedge clk);
    asleep <= 1'b1;
    @(posedge clk);
    asleep <= 1'b0;
    repeat (2) @(posedge clk);
    chk("wake irq", {7'h0, irq}, 8'h01);
    br(8'h80);
    chk("wake cleared", {7'h0, irq}, 8'h00);
    $display("test wake done");
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      end_sim;
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    t_reset;
    t_codes;
    t_ch0;
    t_timer;
    t_retrig;
    t_wake;
    end_sim;
  end
endmodule

// ===== gitm_map.vh
`ifndef GITM_MAP_VH
`define GITM_MAP_VH
// Register byte offsets
`define GITM_A_FLAGS    8'h80
`define GITM_A_CODE_LO  8'h81
`define GITM_A_CODE_MID 8'h82
`define GITM_A_CODE_HI  8'h83
`define GITM_A_TCMD     8'h84
`define GITM_A_GAP      8'h85
`define GITM_A_TLOW     8'h86
`define GITM_A_THIGH    8'h87
`define GITM_A_PINLVL   8'h90
`define GITM_A_CTRL     8'h9C
// Channel count
`define GITM_NCHAN      8
// Own control register bits
`define GITM_CTRL_SLAVE 0
`define GITM_CTRL_WAKE  1
// Channel source codes
`define GITM_C_NONE     3'h0
`define GITM_C_RXLINE   3'h1
`define GITM_C_RXTO     3'h2
`define GITM_C_TX       3'h3
`define GITM_C_MODEM    3'h4
`define GITM_C_PIN      3'h6
`define GITM_C_TIMER    3'h7
// Timer commands
`define GITM_K_IEN      4'h1
`define GITM_K_IDIS     4'h2
`define GITM_K_ONESHOT  4'h3
`define GITM_K_RETRIG   4'h4
`define GITM_K_INTCLK   4'h5
`define GITM_K_EXTCLK   4'h6
`define GITM_K_ROUTE    4'h7
`define GITM_K_UNROUTE  4'h8
`define GITM_K_START    4'h9
`define GITM_K_STOP     4'hA
`define GITM_K_RESET    4'hB
`define GITM_STAT_PEND  8'h01
`define GITM_ZERO8      8'h00
`define GITM_ZERO16     16'h0000
`define GITM_ONE16      16'h0001
`endif

// ===== gitm_pin_model.sv
`timescale 1ns/1ns
module gitm_pin_model (
  input  wire  clk,          // Clock
  input  wire  nrst,         // Reset, active low
  input  wire  raise,        // Pin event from bench
  input  wire  pin_lvl_read, // Level register read
  output logic pin_irq       // Pending pin interrupt
);
  always @(posedge clk or negedge nrst)
    if (!nrst) pin_irq <= 1'b0;
    else if (raise) pin_irq <= 1'b1;
    else if (pin_lvl_read) pin_irq <= 1'b0;
endmodule
